// ==== rtl/msp_pkg.sv ====
/*
  Shared constants for the motion sensor serial port: command layout,
  byte size and the command spacing times with their cycle counts.
  Assumes a single 40 MHz clock shared by both ends.
*/
package msp_pkg;
  localparam int CLK_MHZ = 40;
  localparam int BYTE_BITS = 8;
  localparam int DIR_BIT = 7;
  localparam logic DIR_WRITE = 1'b1;
  localparam int ADDR_BITS = 7;
  // Register addresses inside the sensor model
  localparam logic [6:0] ADDR_MOTION = 7'h02;
  localparam logic [6:0] ADDR_DELTA_X = 7'h03;
  localparam logic [6:0] ADDR_DELTA_Y = 7'h04;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h3a;
  localparam logic [6:0] ADDR_SHUTDOWN = 7'h3b;
  localparam logic [7:0] SOFT_RESET_KEY = 8'h5a;
  localparam logic [7:0] SHUTDOWN_KEY = 8'he7;
  localparam logic [7:0] MOTION_FLAG_RESET = 8'h80;
  // Timing in natural units
  localparam int WRITE_WRITE_GAP_US = 30;
  localparam int WRITE_READ_GAP_US = 20;
  localparam int READ_NEXT_GAP_NS = 500;
  localparam int READ_ADDR_DATA_GAP_US = 4;
  localparam int BURST_EXIT_TIME_NS = 500;
  localparam int WRITE_CS_HOLD_US = 20;
  localparam int RESET_TO_VALID_TIME_MS = 23;
  localparam int SCLK_HALF_NS = 500;
  // Cycle counts, least times rounded up
  localparam int WRITE_WRITE_GAP_CYC = WRITE_WRITE_GAP_US * CLK_MHZ;
  localparam int WRITE_READ_GAP_CYC = WRITE_READ_GAP_US * CLK_MHZ;
  localparam int READ_NEXT_GAP_CYC = (READ_NEXT_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_ADDR_DATA_GAP_CYC = READ_ADDR_DATA_GAP_US * CLK_MHZ;
  localparam int BURST_EXIT_TIME_CYC =
    (BURST_EXIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int WRITE_CS_HOLD_CYC = WRITE_CS_HOLD_US * CLK_MHZ;
  localparam int RESET_TO_VALID_TIME_CYC =
    RESET_TO_VALID_TIME_MS * 1000 * CLK_MHZ;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
endpackage

// ==== rtl/msp_if.sv ====
/*
  Four-wire serial link between the master and the sensor.
  Assumes both ends run on the same clock; the bench resolves miso from
  its enable when the bus is shared.
*/
`timescale 1ns/1ps
interface msp_if;
  logic sclk;
  logic mosi;
  logic chip_select_n;
  logic miso_o;
  logic miso_oe;
  modport sensor (
    input sclk,
    input mosi,
    input chip_select_n,
    output miso_o,
    output miso_oe
  );
  modport master (
    output sclk,
    output mosi,
    output chip_select_n,
    input miso_o,
    input miso_oe
  );
endinterface

// ==== rtl/msp_sensor.sv ====
/*
  Sensor end of the serial port: command decode, small register set,
  motion indication, reset-to-valid timer and laser pulsing.
  Assumes sclk, mosi and chip_select_n are synchronous to clk and the
  master keeps the required command spacing.
*/
`timescale 1ns/1ps
module msp_sensor #(
  parameter int RESET_VALID_CYC = msp_pkg::RESET_TO_VALID_TIME_CYC,
  parameter int FRAME_CYC = 4000,
  parameter int FLASH_CYC = 40
) (
  // System
  input wire logic clk,
  input wire logic reset,
  // Serial link
  msp_if.sensor link,
  // Motion source
  input wire logic move_valid,
  input wire logic [7:0] move_dx,
  input wire logic [7:0] move_dy,
  // Status
  output logic motion_n,
  output logic laser_en_n,
  output logic motion_valid,
  output logic shutdown
);
  import msp_pkg::*;

  // Refuse a flash that does not fit in a frame, or a zero timer
  if (FLASH_CYC < 1 || FLASH_CYC >= FRAME_CYC ||
      RESET_VALID_CYC < 1) begin : g_bad_timing
    $error("msp_sensor: bad timing parameters");
  end

  logic sclk_d_reg;
  logic [2:0] bit_cnt_reg;
  logic phase_data_reg;
  logic [7:0] shift_reg;
  logic [7:0] cmd_reg;
  logic [7:0] tx_reg;
  logic miso_reg;
  logic miso_oe_reg;
  logic [7:0] dx_reg;
  logic [7:0] dy_reg;
  logic dx_read_reg;
  logic dy_read_reg;
  logic pending_reg;
  logic [31:0] valid_cnt_reg;
  logic [31:0] frame_cnt_reg;
  logic selected;
  logic rise;
  logic fall;
  logic byte_done;
  logic [7:0] rx_byte;
  logic wr_done;
  logic addr_done;
  logic [7:0] rd_data;

  assign selected = !link.chip_select_n;
  assign rise = selected && link.sclk && !sclk_d_reg;
  assign fall = selected && !link.sclk && sclk_d_reg;
  assign rx_byte = {shift_reg[6:0], link.mosi};
  assign byte_done = rise && bit_cnt_reg == 3'd7;
  assign addr_done = byte_done && !phase_data_reg;
  assign wr_done = byte_done && phase_data_reg &&
                   cmd_reg[DIR_BIT] == DIR_WRITE;

  always_ff @(posedge clk) begin
    if (reset) sclk_d_reg <= 1'b1;
    else sclk_d_reg <= link.sclk;
  end

  // Bit and byte framing; deselect clears everything
  always_ff @(posedge clk) begin
    if (reset || !selected) begin
      bit_cnt_reg <= 3'd0;
      phase_data_reg <= 1'b0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
    end else if (rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'd1;
      shift_reg <= rx_byte;
      if (addr_done) begin
        cmd_reg <= rx_byte;
        phase_data_reg <= 1'b1;
      end else if (byte_done && cmd_reg[DIR_BIT] == DIR_WRITE) begin
        phase_data_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    case (rx_byte[6:0])
      ADDR_MOTION: rd_data = {pending_reg, 7'h00};
      ADDR_DELTA_X: rd_data = dx_reg;
      ADDR_DELTA_Y: rd_data = dy_reg;
      default: rd_data = 8'h00;
    endcase
  end

  // Data latched at address end, shifted on falling edges
  always_ff @(posedge clk) begin
    if (reset || !selected) begin
      tx_reg <= 8'h00;
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else begin
      miso_oe_reg <= 1'b1;
      if (addr_done && rx_byte[DIR_BIT] != DIR_WRITE) begin
        tx_reg <= rd_data;
      end else if (fall && phase_data_reg &&
                   cmd_reg[DIR_BIT] != DIR_WRITE) begin
        miso_reg <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end
  assign link.miso_o = miso_reg;
  assign link.miso_oe = miso_oe_reg;

  // Motion accumulation and pending flag; new motion wins over clear
  always_ff @(posedge clk) begin
    if (reset) begin
      dx_reg <= 8'h00;
      dy_reg <= 8'h00;
      dx_read_reg <= 1'b0;
      dy_read_reg <= 1'b0;
      pending_reg <= 1'b0;
    end else begin
      if (addr_done && rx_byte[DIR_BIT] != DIR_WRITE) begin
        if (rx_byte[6:0] == ADDR_DELTA_X) dx_read_reg <= 1'b1;
        if (rx_byte[6:0] == ADDR_DELTA_Y) dy_read_reg <= 1'b1;
      end
      if (move_valid && motion_valid && !shutdown) begin
        dx_reg <= dx_reg + move_dx;
        dy_reg <= dy_reg + move_dy;
        pending_reg <= 1'b1;
        dx_read_reg <= 1'b0;
        dy_read_reg <= 1'b0;
      end else if ((dx_read_reg && dy_read_reg) ||
                   (wr_done && cmd_reg[6:0] == ADDR_MOTION)) begin
        pending_reg <= 1'b0;
        dx_reg <= 8'h00;
        dy_reg <= 8'h00;
        dx_read_reg <= 1'b0;
        dy_read_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) motion_n <= 1'b1;
    else motion_n <= !pending_reg;
  end

  // Shutdown and reset-to-valid timer
  always_ff @(posedge clk) begin
    if (reset) begin
      shutdown <= 1'b0;
      valid_cnt_reg <= 32'd0;
      motion_valid <= 1'b0;
    end else if (wr_done && cmd_reg[6:0] == ADDR_SOFT_RESET &&
                 rx_byte == SOFT_RESET_KEY) begin
      shutdown <= 1'b0;
      valid_cnt_reg <= 32'd0;
      motion_valid <= 1'b0;
    end else if (wr_done && cmd_reg[6:0] == ADDR_SHUTDOWN &&
                 rx_byte == SHUTDOWN_KEY) begin
      shutdown <= 1'b1;
      motion_valid <= 1'b0;
    end else if (!shutdown && !motion_valid) begin
      if (valid_cnt_reg == 32'(RESET_VALID_CYC - 1)) motion_valid <= 1'b1;
      else valid_cnt_reg <= valid_cnt_reg + 32'd1;
    end
  end

  // Laser flashes briefly at the start of each frame
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_cnt_reg <= 32'd0;
      laser_en_n <= 1'b1;
    end else if (shutdown) begin
      frame_cnt_reg <= 32'd0;
      laser_en_n <= 1'b1;
    end else begin
      if (frame_cnt_reg == 32'(FRAME_CYC - 1)) frame_cnt_reg <= 32'd0;
      else frame_cnt_reg <= frame_cnt_reg + 32'd1;
      laser_en_n <= !(frame_cnt_reg < 32'(FLASH_CYC));
    end
  end
endmodule

// ==== rtl/msp_master.sv ====
/*
  Master end: runs one read or write command per request, generating
  sclk from a divider and keeping the command spacing times.
  Assumes the sensor end samples on rising and drives on falling edges.
*/
`timescale 1ns/1ps
module msp_master (
  // System
  input wire logic clk,
  input wire logic reset,
  // Serial link
  msp_if.master link,
  // Command port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);
  import msp_pkg::*;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_WAIT, ST_DATA, ST_HOLD, ST_GAP
  } msp_state_e;
  msp_state_e state_reg;
  logic [31:0] tmr_reg;
  logic [7:0] half_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [7:0] rx_reg;
  // Data byte taken with the request, so the caller may move on
  logic [7:0] data_reg;
  logic wr_reg;
  logic last_wr_reg;
  logic [31:0] since_reg;
  logic tick;

  assign tick = half_reg == 8'(SCLK_HALF_CYC - 1);

  always_ff @(posedge clk) begin
    if (reset || state_reg == ST_IDLE || state_reg == ST_WAIT ||
        state_reg == ST_HOLD || state_reg == ST_GAP || tick)
      half_reg <= 8'd0;
    else half_reg <= half_reg + 8'd1;
  end

  // Time since last write data end, for write spacing
  always_ff @(posedge clk) begin
    if (reset) since_reg <= 32'(WRITE_WRITE_GAP_CYC);
    else if (state_reg == ST_HOLD && tmr_reg == 32'd0 && wr_reg)
      since_reg <= 32'(WRITE_CS_HOLD_CYC);
    else if (since_reg != 32'hffffffff) since_reg <= since_reg + 32'd1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      link.sclk <= 1'b1;
      link.mosi <= 1'b0;
      link.chip_select_n <= 1'b1;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      tmr_reg <= 32'd0;
      bit_reg <= 4'd0;
      sh_reg <= 8'h00;
      data_reg <= 8'h00;
      rx_reg <= 8'h00;
      wr_reg <= 1'b0;
      last_wr_reg <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // spacing counted from the last write data edge
          if (req_valid && (!last_wr_reg || since_reg >= 32'(req_write ?
              WRITE_WRITE_GAP_CYC : WRITE_READ_GAP_CYC))) begin
            req_ready <= 1'b0;
            wr_reg <= req_write;
            sh_reg <= {req_write, req_addr};
            data_reg <= req_data;
            link.chip_select_n <= 1'b0;
            bit_reg <= 4'd0;
            state_reg <= ST_ADDR;
          end
        end
        ST_ADDR, ST_DATA: begin
          if (tick) begin
            if (link.sclk) begin
              link.sclk <= 1'b0;
              link.mosi <= sh_reg[7];
              sh_reg <= {sh_reg[6:0], 1'b0};
            end else begin
              link.sclk <= 1'b1;
              rx_reg <= {rx_reg[6:0], link.miso_o};
              bit_reg <= bit_reg + 4'd1;
              if (bit_reg == 4'd7) begin
                bit_reg <= 4'd0;
                if (state_reg == ST_ADDR) begin
                  sh_reg <= data_reg;
                  tmr_reg <= wr_reg ? 32'd0 : 32'(READ_ADDR_DATA_GAP_CYC);
                  state_reg <= ST_WAIT;
                end else begin
                  tmr_reg <= wr_reg ? 32'(WRITE_CS_HOLD_CYC) :
                             32'(SCLK_HALF_CYC);
                  state_reg <= ST_HOLD;
                end
              end
            end
          end
        end
        ST_WAIT: begin
          if (tmr_reg == 32'd0) state_reg <= ST_DATA;
          else tmr_reg <= tmr_reg - 32'd1;
        end
        ST_HOLD: begin
          if (tmr_reg == 32'd0) begin
            link.chip_select_n <= 1'b1;
            last_wr_reg <= wr_reg;
            if (!wr_reg) begin
              rsp_valid <= 1'b1;
              rsp_data <= rx_reg;
            end
            tmr_reg <= 32'(READ_NEXT_GAP_CYC + BURST_EXIT_TIME_CYC);
            state_reg <= ST_GAP;
          end else tmr_reg <= tmr_reg - 32'd1;
        end
        ST_GAP: begin
          if (tmr_reg == 32'd0) begin
            req_ready <= 1'b1;
            state_reg <= ST_IDLE;
          end else tmr_reg <= tmr_reg - 32'd1;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== verif/msp_properties.sv ====
/*
  Checker for the serial link between master and sensor.
  Assumes it is tied by name to the link signals and the one clock.
*/
`timescale 1ns/1ps
module msp_properties
  import msp_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic reset,
  // Link
  input wire logic sclk,
  input wire logic mosi,
  input wire logic chip_select_n,
  input wire logic miso_o,
  input wire logic miso_oe
);
  logic sclk_q;
  logic dir_q;
  logic [4:0] bit_cnt;
  logic [15:0] rise_age;
  logic [15:0] wr_age;
  logic [15:0] rd_age;
  logic [15:0] hi_age;
  wire rise = sclk && !sclk_q;
  wire last = rise && bit_cnt == 5'h0f;

  function automatic logic [15:0] sat(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  // Bit position and direction of the command in flight
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    if (reset || chip_select_n) begin
      bit_cnt <= 5'h00;
    end else if (rise) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
    if (rise && bit_cnt == 5'h00) begin
      dir_q <= mosi;
    end
  end

  // Cycles since each spacing event, saturating
  always_ff @(posedge clk) begin
    rise_age <= reset ? 16'hffff : rise ? 16'h0001 : sat(rise_age);
    wr_age <= reset ? 16'hffff : (last && dir_q) ? 16'h0001 : sat(wr_age);
    rd_age <= reset ? 16'hffff : (last && !dir_q) ? 16'h0001 : sat(rd_age);
    hi_age <= reset ? 16'hffff : chip_select_n ? sat(hi_age) : 16'h0000;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence cmd_start_s;
    $fell(sclk) && !chip_select_n && bit_cnt == 5'h00;
  endsequence
  sequence rd_data_start_s;
    $fell(sclk) && !chip_select_n && bit_cnt == 5'h08 && !dir_q;
  endsequence

  a_deselect_float: assert property (
    chip_select_n && $past(chip_select_n) |-> !miso_oe)
    else $error("miso driven while deselected");
  a_miso_on_low: assert property (
    miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sclk)
    else $error("miso changed while sclk high");
  a_sclk_idle_high: assert property (
    chip_select_n |-> sclk)
    else $error("sclk low while deselected");
  a_whole_cmd: assert property (
    $rose(chip_select_n) |-> bit_cnt == 5'h10)
    else $error("command not two whole bytes");
  a_write_hold: assert property (
    $rose(chip_select_n) && dir_q |-> rise_age >= WRITE_CS_HOLD_CYC)
    else $error("select raised too soon after write");
  a_addr_data_gap: assert property (
    rd_data_start_s |-> rise_age >= READ_ADDR_DATA_GAP_CYC)
    else $error("read data clocked too early");
  a_write_write: assert property (
    last && dir_q |-> wr_age >= WRITE_WRITE_GAP_CYC)
    else $error("writes too close");
  a_write_read: assert property (
    rise && bit_cnt == 5'h07 && !dir_q |-> wr_age >= WRITE_READ_GAP_CYC)
    else $error("read too close after write");
  a_read_next: assert property (
    cmd_start_s |-> rd_age >= READ_NEXT_GAP_CYC)
    else $error("command too close after read");
  a_deselect_time: assert property (
    $fell(chip_select_n) |-> hi_age >= BURST_EXIT_TIME_CYC)
    else $error("select high too briefly");
endmodule

// ==== verif/motion_sensor_serial_port_tb.sv ====
/*
  Bench: master and sensor joined by a link, plus a second sensor whose
  link the bench drives by hand to break the framing on purpose.
  Assumes the package, interface and both ends compile first.
*/
`timescale 1ns/1ps
module motion_sensor_serial_port_tb;
  import msp_pkg::*;
  localparam int RV = 2000;
  logic clk, reset, req_valid, req_write, req_ready, rsp_valid;
  logic [6:0] req_addr;
  logic [7:0] req_data, rsp_data, move_dx, move_dy, rd;
  logic move_valid, motion_n, motion_n_b, motion_valid, shutdown, laser_en_n;
  int n_errors = 0;
  int cmp_count = 0;
  msp_if link ();
  msp_if link_b ();
  msp_master u_msp_master (.clk(clk), .reset(reset), .link(link),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  msp_sensor #(.RESET_VALID_CYC(RV), .FRAME_CYC(400), .FLASH_CYC(10))
    u_msp_sensor (.clk(clk), .reset(reset), .link(link),
    .move_valid(move_valid), .move_dx(move_dx), .move_dy(move_dy),
    .motion_n(motion_n), .laser_en_n(laser_en_n),
    .motion_valid(motion_valid), .shutdown(shutdown));
  msp_sensor #(.RESET_VALID_CYC(RV)) u_msp_sensor_b (.clk(clk),
    .reset(reset), .link(link_b), .move_valid(move_valid),
    .move_dx(move_dx), .move_dy(move_dy), .motion_n(motion_n_b),
    .laser_en_n(), .motion_valid(), .shutdown());
  msp_properties u_msp_properties (.clk(clk), .reset(reset),
    .sclk(link.sclk), .mosi(link.mosi), .chip_select_n(link.chip_select_n),
    .miso_o(link.miso_o), .miso_oe(link.miso_oe));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic hang;
    n_errors++;
    $display("[FAIL] %0t timeout", $time);
    complete_run();
  endtask
  task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] d);
    int i;
    for (i = 0; i < 3000 && req_ready !== 1'b1; i++) step(1);
    if (req_ready !== 1'b1) hang();
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_data = d;
    rd = 8'hxx;
    for (i = 0; i < 3000 && req_ready === 1'b1; i++) step(1);
    req_valid = 1'b0;
    if (req_ready === 1'b1) hang();
    for (i = 0; i < 3000 && req_ready !== 1'b1; i++) begin
      step(1);
      if (rsp_valid === 1'b1) rd = rsp_data;
    end
    if (req_ready !== 1'b1) hang();
  endtask
  task automatic move(input logic [7:0] dx, input logic [7:0] dy);
    move_dx = dx;
    move_dy = dy;
    move_valid = 1'b1;
    step(1);
    move_valid = 1'b0;
    step(2);
  endtask
  task automatic wait_valid;
    int i;
    chk(motion_valid, 1'b0);
    for (i = 0; i < RV + 2 && motion_valid !== 1'b1; i++) step(1);
    chk(motion_valid, 1'b1);
    if (motion_valid !== 1'b1) complete_run();
  endtask
  task automatic t_reset_state;
    chk(link.miso_oe, 1'b0);
    chk(link.chip_select_n, 1'b1);
    chk(link.sclk, 1'b1);
    chk(req_ready, 1'b1);
    chk(motion_n, 1'b1);
    chk(laser_en_n, 1'b1);
    wait_valid();
  endtask
  // Hand-driven bits on the second link, MSB first
  task automatic bang(input logic [7:0] b, input int n);
    int i;
    for (i = 7; i > 7 - n; i--) begin
      link_b.sclk = 1'b0;
      link_b.mosi = b[i];
      step(20);
      link_b.sclk = 1'b1;
      step(20);
    end
  endtask

  task automatic t_motion_read;
    chk(motion_n, 1'b1);
    move(8'h05, 8'hfd);
    chk(motion_n, 1'b0);
    cmd(1'b0, ADDR_MOTION, 8'h00);
    chk(rd[7], 1'b1);
    cmd(1'b0, ADDR_DELTA_X, 8'h00);
    chk(rd, 8'h05);
    chk(motion_n, 1'b0);
    cmd(1'b0, ADDR_DELTA_Y, 8'h00);
    chk(rd, 8'hfd);
    chk(motion_n, 1'b1);
  endtask
  task automatic t_write_clear;
    move(8'h01, 8'h02);
    chk(motion_n, 1'b0);
    cmd(1'b1, ADDR_MOTION, 8'h00);
    chk(motion_n, 1'b1);
    cmd(1'b0, ADDR_MOTION, 8'h00);
    chk(rd[7], 1'b0);
  endtask
  task automatic t_abort;
    bang({DIR_WRITE, ADDR_MOTION}, 8);
    bang(8'h00, 8);
    chk(motion_n_b, 1'b0);
    link_b.chip_select_n = 1'b0;
    step(20);
    bang({DIR_WRITE, ADDR_MOTION}, 8);
    bang(8'h00, 4);
    link_b.chip_select_n = 1'b1;
    step(40);
    chk(motion_n_b, 1'b0);
    chk(link_b.miso_oe, 1'b0);
    // A leftover half frame would finish the motion write here
    link_b.chip_select_n = 1'b0;
    step(20);
    bang({DIR_WRITE, ADDR_DELTA_X}, 8);
    bang(8'h00, 8);
    step(WRITE_CS_HOLD_CYC);
    link_b.chip_select_n = 1'b1;
    step(40);
    chk(motion_n_b, 1'b0);
    link_b.chip_select_n = 1'b0;
    step(20);
    bang({DIR_WRITE, ADDR_MOTION}, 8);
    bang(8'h00, 8);
    step(WRITE_CS_HOLD_CYC);
    link_b.chip_select_n = 1'b1;
    step(2);
    chk(motion_n_b, 1'b1);
  endtask
  task automatic t_shutdown_wake;
    cmd(1'b1, ADDR_SHUTDOWN, SHUTDOWN_KEY);
    chk(shutdown, 1'b1);
    chk(laser_en_n, 1'b1);
    move(8'h01, 8'h01);
    chk(motion_n, 1'b1);
    cmd(1'b1, ADDR_SOFT_RESET, SOFT_RESET_KEY);
    chk(shutdown, 1'b0);
    wait_valid();
  endtask
  task automatic t_laser;
    int i;
    int lo = 0;
    for (i = 0; i < 400; i++) begin
      step(1);
      if (laser_en_n === 1'b0) lo++;
    end
    chk(lo[7:0], 8'h0a);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 7'h00;
    req_data = 8'h00;
    move_valid = 1'b0;
    move_dx = 8'h00;
    move_dy = 8'h00;
    link_b.sclk = 1'b1;
    link_b.mosi = 1'b0;
    link_b.chip_select_n = 1'b1;
    step(8);
    reset = 1'b0;
    t_reset_state();
    t_motion_read();
    t_write_clear();
    t_abort();
    t_shutdown_wake();
    t_laser();
    complete_run();
  end
endmodule
